// *** hw/accel_regs_params.svh ***
`ifndef ACCEL_REGS_PARAMS_SVH
`define ACCEL_REGS_PARAMS_SVH

// Register addresses
`define ADDR_STATUS    8'h00
`define ADDR_X_HIGH    8'h01
`define ADDR_X_LOW     8'h02
`define ADDR_Y_HIGH    8'h03
`define ADDR_Y_LOW     8'h04
`define ADDR_Z_HIGH    8'h05
`define ADDR_Z_LOW     8'h06
`define ADDR_IDENT     8'h0D
`define ADDR_CTRL1     8'h2A
`define ADDR_CTRL2     8'h2B
`define ADDR_CTRL3     8'h2C
`define ADDR_CTRL4     8'h2D
`define ADDR_CTRL5     8'h2E
`define ADDR_OFF_X     8'h2F
`define ADDR_OFF_Y     8'h30
`define ADDR_OFF_Z     8'h31
`define ADDR_RSVD_LO   8'h40
`define ADDR_RSVD_HI   8'h7F
`define ADDR_CLEARED   8'h00

// Field positions
`define BIT_ACTIVE     0
`define BIT_FAST_READ  1
`define BIT_SOFT_RST   6

// Reset values
`define RST_CTRL       8'h00
`define RST_OFFSET     8'h00
`define RST_SAMPLE     10'h000

// Bus agent address and identity byte (values arbitrary)
`define BUS_ADDR_DEF   7'h3C
`define IDENT_DEF      8'hA5

// Protocol counts
`define BITS_PER_BYTE  4'h8

`endif

// *** hw/accel_regs_pkg.sv ***
package accel_regs_pkg;

    typedef logic [9:0] axis_word_t;
    typedef logic [2:0] axis_mask_t;

    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_ADDR   = 4'h1,
        ST_ACK_A  = 4'h2,
        ST_REG    = 4'h3,
        ST_ACK_R  = 4'h4,
        ST_WR     = 4'h5,
        ST_ACK_W  = 4'h6,
        ST_RD     = 4'h7,
        ST_RD_ACK = 4'h8
    } bus_state_t;

    // Sample-clock side of the handshake
    typedef struct packed {
        logic [2:0][9:0] hold;
        axis_mask_t      mask;
        logic            req;
        logic            ack_m;
        logic            ack_s;
        logic            ready;
    } smp_state_t;

    // System-clock side: bus engine, registers and flags
    typedef struct packed {
        bus_state_t      state;
        logic [3:0]      cnt;
        logic [7:0]      shift;
        logic [7:0]      tx;
        logic            rw;
        logic            wrote;
        logic            mack;
        logic [7:0]      ptr;
        logic            sda_oe_n;
        logic            sda_out;
        logic            scl_m;
        logic            scl_s;
        logic            scl_p;
        logic            sda_m;
        logic            sda_s;
        logic            sda_p;
        logic            req_m;
        logic            req_s;
        logic            req_p;
        logic [7:0]      ctrl1;
        logic [7:0]      ctrl2;
        logic [7:0]      ctrl3;
        logic [7:0]      ctrl4;
        logic [7:0]      ctrl5;
        logic [7:0]      off_x;
        logic [7:0]      off_y;
        logic [7:0]      off_z;
        logic [2:0][9:0] smp;
        logic [2:0][1:0] lsb;
        axis_mask_t      dr;
        axis_mask_t      ow;
        logic            any_dr;
        logic            any_ow;
        logic            active;
    } sys_state_t;

endpackage

// *** hw/accel_sample_status_regs.sv ***
// Function
// - Set combined overwrite on unread set replaced
// - Clear combined overwrite after all active highs read
// - Axis overwrite flag set, sample replaced
// - Axis high-byte read clears axis overwrite
// - Combined ready on new data, cleared after reads
// - Axis ready set on sample, cleared by read
// - Samples are signed two's complement
// - High byte bits 9..2, low byte 1..0, X,Y,Z
// - Sample registers keep latest sample
// - Active to standby preserves all registers
// - Standby to active resets status and samples
// - Config writes only in standby, except active/reset
// - Auto-increment only in burst reads
// - Stop condition clears stored address
// - Control range increments; after Z offset go 0x0D
// - Reserved range 0x40..0x7F reads zero
// - Control register one resets to zero
// - Fast-read skips low-byte registers
// - Low byte follows high byte, same sample
`include "accel_regs_params.svh"

module accel_sample_status_regs #(
    parameter logic [6:0] BUS_ADDR   = `BUS_ADDR_DEF,
    parameter logic [7:0] IDENT_BYTE = `IDENT_DEF     // Arbitrary identity value
) (
    input  wire logic                        SYS_CLK,
    input  wire logic                        RESET_N,
    input  wire logic                        SCL_IN,
    input  wire logic                        SDA_IN,
    output logic                             SDA_OUT,
    output logic                             SDA_OE_N,
    input  wire logic                        SAMPLE_CLK,
    input  wire logic                        SAMPLE_VALID,
    input  wire accel_regs_pkg::axis_mask_t  SAMPLE_AXIS_EN,
    input  wire accel_regs_pkg::axis_word_t  SAMPLE_X,
    input  wire accel_regs_pkg::axis_word_t  SAMPLE_Y,
    input  wire accel_regs_pkg::axis_word_t  SAMPLE_Z,
    output logic                             SAMPLE_READY,
    output logic                             DEVICE_ACTIVE
);
    import accel_regs_pkg::*;

    smp_state_t  p_q;
    smp_state_t  p_d;
    sys_state_t  s_q;
    sys_state_t  s_d;

    logic        scl_rise;
    logic        scl_fall;
    logic        start_det;
    logic        stop_det;
    logic        fetch;
    logic        new_set;
    axis_mask_t  new_mask;
    axis_mask_t  rd_clr;
    logic [7:0]  rd_byte;

    // Next read address; fast read skips the low bytes
    function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fr);
        logic [7:0] r;
        r = a + 8'h01;
        case (a)
            `ADDR_X_HIGH: r = fr ? `ADDR_Y_HIGH : `ADDR_X_LOW;
            `ADDR_Y_HIGH: r = fr ? `ADDR_Z_HIGH : `ADDR_Y_LOW;
            `ADDR_Z_HIGH: r = fr ? `ADDR_STATUS : `ADDR_Z_LOW;
            `ADDR_Z_LOW:  r = `ADDR_STATUS;
            `ADDR_OFF_Z:  r = `ADDR_IDENT;
            default:      r = a + 8'h01;
        endcase
        return r;
    endfunction

    // Read decode; holes and the reserved range return zero
    function automatic logic [7:0] read_reg(input sys_state_t s, input logic [7:0] a,
                                            input logic [7:0] id);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            `ADDR_STATUS: r = {s.any_ow, s.ow[2], s.ow[1], s.ow[0],
                               s.any_dr, s.dr[2], s.dr[1], s.dr[0]};
            `ADDR_X_HIGH: r = s.smp[0][9:2];
            `ADDR_X_LOW:  r = {s.lsb[0], 6'h00};
            `ADDR_Y_HIGH: r = s.smp[1][9:2];
            `ADDR_Y_LOW:  r = {s.lsb[1], 6'h00};
            `ADDR_Z_HIGH: r = s.smp[2][9:2];
            `ADDR_Z_LOW:  r = {s.lsb[2], 6'h00};
            `ADDR_IDENT:  r = id;
            `ADDR_CTRL1:  r = s.ctrl1;
            `ADDR_CTRL2:  r = s.ctrl2;
            `ADDR_CTRL3:  r = s.ctrl3;
            `ADDR_CTRL4:  r = s.ctrl4;
            `ADDR_CTRL5:  r = s.ctrl5;
            `ADDR_OFF_X:  r = s.off_x;
            `ADDR_OFF_Y:  r = s.off_y;
            `ADDR_OFF_Z:  r = s.off_z;
            default:      r = 8'h00;
        endcase
        return r;
    endfunction

    // Sample clock: capture a set only when the previous one was taken over
    always_comb begin
        p_d       = p_q;
        p_d.ack_m = s_q.req_p;
        p_d.ack_s = p_q.ack_m;
        if (SAMPLE_VALID && p_q.ready) begin
            p_d.hold = {SAMPLE_Z, SAMPLE_Y, SAMPLE_X};
            p_d.mask = SAMPLE_AXIS_EN;
            p_d.req  = ~p_q.req;
        end
        p_d.ready = (p_d.req == p_d.ack_s);
    end

    always_ff @(posedge SAMPLE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            p_q       <= '0;
            p_q.ready <= 1'b1;
        end else begin
            p_q <= p_d;
        end
    end

    // Line events seen through the synchronisers
    assign scl_rise  = s_q.scl_s & ~s_q.scl_p;
    assign scl_fall  = ~s_q.scl_s & s_q.scl_p;
    assign start_det = s_q.scl_s & s_q.scl_p & s_q.sda_p & ~s_q.sda_s;
    assign stop_det  = s_q.scl_s & s_q.scl_p & ~s_q.sda_p & s_q.sda_s;
    assign fetch     = scl_fall & ~start_det & ~stop_det &
                       (((s_q.state == ST_ACK_A) & s_q.rw) |
                        ((s_q.state == ST_RD_ACK) & s_q.mack));
    assign rd_byte   = read_reg(s_q, s_q.ptr, IDENT_BYTE);

    // Held words are stable while the toggle differs, so they cross as bundled data
    assign new_set   = s_q.req_s ^ s_q.req_p;
    assign new_mask  = (new_set & s_q.active) ? p_q.mask : 3'h0;
    assign rd_clr    = {3{fetch}} & {s_q.ptr == `ADDR_Z_HIGH, s_q.ptr == `ADDR_Y_HIGH,
                                     s_q.ptr == `ADDR_X_HIGH};

    // Bus engine, flag update and register writes
    always_comb begin
        s_d        = s_q;
        s_d.scl_m  = SCL_IN;
        s_d.scl_s  = s_q.scl_m;
        s_d.scl_p  = s_q.scl_s;
        s_d.sda_m  = SDA_IN;
        s_d.sda_s  = s_q.sda_m;
        s_d.sda_p  = s_q.sda_s;
        s_d.req_m  = p_q.req;
        s_d.req_s  = s_q.req_m;
        s_d.req_p  = s_q.req_s;
        s_d.active = s_q.ctrl1[`BIT_ACTIVE];
        if (stop_det) begin
            s_d.state    = ST_IDLE;
            s_d.ptr      = `ADDR_CLEARED;
            s_d.sda_oe_n = 1'b1;
        end else if (start_det) begin
            s_d.state    = ST_ADDR;
            s_d.cnt      = 4'h0;
            s_d.wrote    = 1'b0;
            s_d.sda_oe_n = 1'b1;
        end else if (scl_rise) begin
            if ((s_q.state == ST_ADDR || s_q.state == ST_REG || s_q.state == ST_WR) &&
                s_q.cnt != `BITS_PER_BYTE) begin
                s_d.shift = {s_q.shift[6:0], s_q.sda_s};
                s_d.cnt   = s_q.cnt + 4'h1;
            end
            if (s_q.state == ST_RD_ACK) begin
                s_d.mack = ~s_q.sda_s;
            end
        end else if (scl_fall) begin
            case (s_q.state)
                ST_ADDR: begin
                    if (s_q.cnt == `BITS_PER_BYTE) begin
                        if (s_q.shift[7:1] == BUS_ADDR) begin
                            s_d.sda_oe_n = 1'b0;
                            s_d.rw       = s_q.shift[0];
                            s_d.state    = ST_ACK_A;
                        end else begin
                            s_d.state = ST_IDLE;
                        end
                    end
                end
                ST_ACK_A: begin
                    if (!s_q.rw) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.state    = ST_REG;
                        s_d.cnt      = 4'h0;
                    end
                end
                ST_REG: begin
                    if (s_q.cnt == `BITS_PER_BYTE) begin
                        s_d.sda_oe_n = 1'b0;
                        s_d.state    = ST_ACK_R;
                    end
                end
                ST_ACK_R: begin
                    s_d.ptr      = s_q.shift;
                    s_d.sda_oe_n = 1'b1;
                    s_d.state    = ST_WR;
                    s_d.cnt      = 4'h0;
                end
                ST_WR: begin
                    // Writes never auto-increment: a second byte is not acknowledged
                    if (s_q.cnt == `BITS_PER_BYTE) begin
                        s_d.sda_oe_n = s_q.wrote;
                        s_d.wrote    = 1'b1;
                        s_d.state    = ST_ACK_W;
                    end
                end
                ST_ACK_W: begin
                    s_d.sda_oe_n = 1'b1;
                    s_d.state    = ST_WR;
                    s_d.cnt      = 4'h0;
                end
                ST_RD: begin
                    if (s_q.cnt == `BITS_PER_BYTE) begin
                        s_d.sda_oe_n = 1'b1;
                        s_d.state    = ST_RD_ACK;
                    end else begin
                        s_d.sda_oe_n = s_q.tx[6];
                        s_d.tx       = {s_q.tx[6:0], 1'b0};
                        s_d.cnt      = s_q.cnt + 4'h1;
                    end
                end
                ST_RD_ACK: begin
                    if (!s_q.mack) begin
                        s_d.state = ST_IDLE;
                    end
                end
                default: s_d.state = ST_IDLE;
            endcase
            if (fetch) begin
                s_d.tx       = rd_byte;
                s_d.sda_oe_n = rd_byte[7];
                s_d.cnt      = 4'h1;
                s_d.state    = ST_RD;
                s_d.ptr      = next_addr(s_q.ptr, s_q.ctrl1[`BIT_FAST_READ]);
            end
        end

        // Flags: a new sample in the clearing cycle still sets ready, but not overwrite
        s_d.dr     = (s_q.dr & ~rd_clr) | new_mask;
        s_d.ow     = (s_q.ow & ~rd_clr) | (new_mask & s_q.dr & ~rd_clr);
        s_d.any_dr = (|new_mask) | (s_q.any_dr & (|s_d.dr));
        s_d.any_ow = (|(new_mask & s_q.dr & ~rd_clr)) |
                     (s_q.any_ow & (|s_d.dr));
        for (int i = 0; i < 3; i++) begin
            if (rd_clr[i]) begin
                s_d.lsb[i] = s_q.smp[i][1:0];
            end
            if (new_mask[i]) begin
                s_d.smp[i] = p_q.hold[i];
            end
        end

        // Register write at the data byte's acknowledge
        if (scl_fall && !start_det && !stop_det && s_q.state == ST_WR &&
            s_q.cnt == `BITS_PER_BYTE && !s_q.wrote) begin
            case (s_q.ptr)
                `ADDR_CTRL1: begin
                    if (s_q.active) begin
                        s_d.ctrl1[`BIT_ACTIVE] = s_q.shift[`BIT_ACTIVE];
                    end else begin
                        s_d.ctrl1 = s_q.shift;
                    end
                end
                `ADDR_CTRL2: begin
                    if (!s_q.active) begin
                        s_d.ctrl2 = s_q.shift;
                    end
                    if (s_q.shift[`BIT_SOFT_RST]) begin
                        s_d.ctrl1 = `RST_CTRL;
                        s_d.ctrl2 = `RST_CTRL;
                        s_d.ctrl3 = `RST_CTRL;
                        s_d.ctrl4 = `RST_CTRL;
                        s_d.ctrl5 = `RST_CTRL;
                        s_d.off_x = `RST_OFFSET;
                        s_d.off_y = `RST_OFFSET;
                        s_d.off_z = `RST_OFFSET;
                    end
                end
                `ADDR_CTRL3: if (!s_q.active) s_d.ctrl3 = s_q.shift;
                `ADDR_CTRL4: if (!s_q.active) s_d.ctrl4 = s_q.shift;
                `ADDR_CTRL5: if (!s_q.active) s_d.ctrl5 = s_q.shift;
                `ADDR_OFF_X: if (!s_q.active) s_d.off_x = s_q.shift;
                `ADDR_OFF_Y: if (!s_q.active) s_d.off_y = s_q.shift;
                `ADDR_OFF_Z: if (!s_q.active) s_d.off_z = s_q.shift;
                default: s_d.ctrl1 = s_d.ctrl1;
            endcase
        end

        // Going active starts from clean status; going to standby keeps all
        // Only the rising edge of the active bit clears, so standby never loses data
        if (s_d.ctrl1[`BIT_ACTIVE] && !s_q.ctrl1[`BIT_ACTIVE]) begin
            s_d.dr     = 3'h0;
            s_d.ow     = 3'h0;
            s_d.any_dr = 1'b0;
            s_d.any_ow = 1'b0;
            s_d.smp    = {3{`RST_SAMPLE}};
            s_d.lsb    = '0;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s_q          <= '0;
            s_q.state    <= ST_IDLE;
            s_q.sda_oe_n <= 1'b1;
            s_q.scl_m    <= 1'b1;
            s_q.scl_s    <= 1'b1;
            s_q.scl_p    <= 1'b1;
            s_q.sda_m    <= 1'b1;
            s_q.sda_s    <= 1'b1;
            s_q.sda_p    <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from flip-flops
    assign SDA_OUT       = s_q.sda_out;
    assign SDA_OE_N      = s_q.sda_oe_n;
    assign SAMPLE_READY  = p_q.ready;
    assign DEVICE_ACTIVE = s_q.active;

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (!RESET_N);

    sequence s_read_x_high;
        fetch && s_q.ptr == `ADDR_X_HIGH;
    endsequence

    // Cycle in which the first data byte of a write lands
    sequence s_data_write;
        scl_fall && !start_det && !stop_det && s_q.state == ST_WR &&
        s_q.cnt == `BITS_PER_BYTE && !s_q.wrote;
    endsequence

    a_axis_ready_set: assert property (new_mask[0] |=> s_q.dr[0])
        else $error("axis ready flag not set by new sample");
    a_axis_ready_clr: assert property (s_read_x_high ##0 !new_mask[0] |=> !s_q.dr[0])
        else $error("axis ready flag not cleared by high-byte read");
    a_axis_ow_set: assert property (new_mask[1] && s_q.dr[1] && !rd_clr[1]
                                    |=> s_q.ow[1] && s_q.any_ow)
        else $error("overwrite flags not set on unread sample");
    a_axis_ow_clr: assert property (rd_clr[2] && !new_mask[2] |=> !s_q.ow[2])
        else $error("axis overwrite not cleared by read");
    a_combined_clr: assert property (s_q.dr == rd_clr && new_mask == 3'h0 && |rd_clr
                                     |=> !s_q.any_dr && !s_q.any_ow)
        else $error("combined flags not cleared after last read");
    a_stop_clears: assert property (stop_det |=> s_q.ptr == `ADDR_CLEARED)
        else $error("stored address survived stop");
    a_offz_wrap: assert property (fetch && s_q.ptr == `ADDR_OFF_Z
                                  |=> s_q.ptr == `ADDR_IDENT)
        else $error("auto-increment after Z offset wrong");
    a_reserved_zero: assert property (fetch && s_q.ptr >= `ADDR_RSVD_LO &&
                                      s_q.ptr <= `ADDR_RSVD_HI |=> s_q.tx == 8'h00)
        else $error("reserved address returned non-zero");
    a_fast_skip: assert property (fetch && s_q.ptr == `ADDR_X_HIGH &&
                                  s_q.ctrl1[`BIT_FAST_READ] |=> s_q.ptr == `ADDR_Y_HIGH)
        else $error("fast read did not skip low byte");
    a_lsb_pair: assert property (s_read_x_high |=> s_q.lsb[0] == $past(s_q.smp[0][1:0]))
        else $error("low byte not from same sample");
    a_standby_only: assert property (s_q.active && s_q.ctrl1[`BIT_ACTIVE] &&
                                     s_d.ctrl1[`BIT_ACTIVE] && s_q.ptr != `ADDR_CTRL2
                                     |=> $stable(s_q.off_x))
        else $error("offset changed while active");
    a_soft_reset: assert property (s_data_write ##0 s_q.ptr == `ADDR_CTRL2 &&
                                   s_q.shift[`BIT_SOFT_RST]
                                   |=> s_q.ctrl1 == `RST_CTRL && s_q.off_x == `RST_OFFSET)
        else $error("soft reset did not restore control registers");
    a_standby_keeps: assert property (s_q.ctrl1[`BIT_ACTIVE] && !s_d.ctrl1[`BIT_ACTIVE] &&
                                      new_mask == 3'h0 |=> $stable(s_q.smp))
        else $error("samples lost on entering standby");
    a_activate_clr: assert property (!s_q.ctrl1[`BIT_ACTIVE] ##1 s_q.ctrl1[`BIT_ACTIVE]
                                     |-> s_q.dr == 3'h0 && !s_q.any_dr)
        else $error("status not reset on activation");
endmodule

// *** sim/host_model.sv ***
// Bus controller on the far side of the data pin; releases the line for a one
module host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h3C
) (
    output logic       scl,
    output logic       sda_drv,
    input  wire logic  sda_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Half bit period well above the four-clock minimum the pin filter needs
    localparam int H = 250;
    localparam int Q = 60;

    logic [7:0] rx [0:7];
    int         nacks;

    // Idle bus: both lines released high
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
        nacks = 0;
    end

    // Data changes only while the clock is low, well after its fall
    task automatic bit_out(input logic b);
        #Q sda_drv = b;
        #(H - Q) scl = 1'b1;
        #H scl = 1'b0;
    endtask

    task automatic bit_in(output logic b);
        #Q sda_drv = 1'b1;
        #(H - Q) scl = 1'b1;
        #(H / 2) b = sda_line;
        #(H / 2) scl = 1'b0;
    endtask

    // Start and repeated start share one shape
    task automatic start_c;
        #Q sda_drv = 1'b1;
        #(H - Q) scl = 1'b1;
        #H sda_drv = 1'b0;
        #H scl = 1'b0;
    endtask

    task automatic stop_c;
        #Q sda_drv = 1'b0;
        #(H - Q) scl = 1'b1;
        #H sda_drv = 1'b1;
        #H;
    endtask

    task automatic put_byte(input logic [7:0] v);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_out(v[i]);
        end
        bit_in(a);
        if (a !== 1'b0) begin
            nacks++;
        end
    endtask

    // Controller acknowledges every byte but the last, which ends the burst
    task automatic rd_cur(input int n);
        logic [7:0] v;
        logic       b;
        start_c;
        put_byte({DEV_ADDR, 1'b1});
        for (int k = 0; k < n; k++) begin
            for (int i = 0; i < 8; i++) begin
                bit_in(b);
                v = {v[6:0], b};
            end
            rx[k] = v;
            bit_out(k == n - 1);
        end
        stop_c;
    endtask

    task automatic rd(input logic [7:0] r, input int n);
        start_c;
        put_byte({DEV_ADDR, 1'b0});
        put_byte(r);
        rd_cur(n);
    endtask

    // Callers keep writes away from the reserved range; s_config also writes an offset while active
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        start_c;
        put_byte({DEV_ADDR, 1'b0});
        put_byte(r);
        put_byte(d);
        stop_c;
    endtask
endmodule

// *** sim/tb.sv ***
module tb;
    import accel_regs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       sys_clk, reset_n, smp_clk, smp_valid, scl, sda_drv;
    logic       sda_out, sda_oe_n, smp_ready, dev_active;
    wire logic  sda_w;
    axis_mask_t axis_en;
    axis_word_t sx, sy, sz;
    int         err_total, num_checks;

    localparam axis_word_t X1 = 10'h3FD, Y1 = 10'h155, Z1 = 10'h200;
    localparam axis_word_t X2 = 10'h0A7, Y2 = 10'h1FF, Z2 = 10'h301, X3 = 10'h2C6;

    // Open-drain data line with pull-up
    assign sda_w = sda_drv & (sda_oe_n ? 1'b1 : sda_out);

    accel_sample_status_regs #(.BUS_ADDR(7'h3C), .IDENT_BYTE(8'h6C)) dut ( // Arbitrary id
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .SCL_IN(scl), .SDA_IN(sda_w),
        .SDA_OUT(sda_out), .SDA_OE_N(sda_oe_n), .SAMPLE_CLK(smp_clk),
        .SAMPLE_VALID(smp_valid), .SAMPLE_AXIS_EN(axis_en), .SAMPLE_X(sx),
        .SAMPLE_Y(sy), .SAMPLE_Z(sz), .SAMPLE_READY(smp_ready),
        .DEVICE_ACTIVE(dev_active));

    host_model #(.DEV_ADDR(7'h3C)) host (.scl(scl), .sda_drv(sda_drv), .sda_line(sda_w));

    // Two unrelated clocks
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        smp_clk = 1'b0;
        #7;
        forever #16 smp_clk = ~smp_clk;
    end

    function automatic logic [7:0] hi(axis_word_t v);
        return v[9:2];
    endfunction
    function automatic logic [7:0] lo(axis_word_t v);
        return {v[1:0], 6'h00};
    endfunction

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] r, input logic [7:0] exp);
        host.rd(r, 1);
        chk(host.rx[0], exp);
    endtask

    // Offer one set on the link, then let it cross into the register clock
    task automatic push(input axis_word_t x, y, z, input axis_mask_t en);
        int i;
        i = 0;
        // Ready is read after the edge that may launch it, not in that time step
        @(posedge smp_clk);
        #2;
        while (smp_ready !== 1'b1 && i < 100) begin
            @(posedge smp_clk);
            #2;
            i++;
        end
        chk({7'h00, smp_ready}, 8'h01);
        smp_valid = 1'b1;
        {sx, sy, sz, axis_en} = {x, y, z, en};
        @(posedge smp_clk);
        #2 smp_valid = 1'b0;
        repeat (20) @(posedge sys_clk);
    endtask

    task automatic s_reset;
        rdchk(8'h00, 8'h00);
        rdchk(8'h2A, 8'h00);
        rdchk(8'h40, 8'h00);
        rdchk(8'h7F, 8'h00);
    endtask

    // Config write lands in standby, is ignored once active
    task automatic s_config;
        host.wr(8'h2F, 8'h5A);
        rdchk(8'h2F, 8'h5A);
        host.wr(8'h2A, 8'h01);
        chk({7'h00, dev_active}, 8'h01);
        host.wr(8'h2F, 8'h11);
        rdchk(8'h2F, 8'h5A);
    endtask

    // Status plus seven bytes wraps back to status, now cleared
    task automatic s_burst;
        logic [7:0] e [0:7];
        push(X1, Y1, Z1, 3'h7);
        e = '{8'h0F, hi(X1), lo(X1), hi(Y1), lo(Y1), hi(Z1), lo(Z1), 8'h00};
        host.rd(8'h00, 8);
        for (int i = 0; i < 8; i++) begin
            chk(host.rx[i], e[i]);
        end
    endtask

    task automatic s_overwrite;
        push(X1, Y1, Z1, 3'h7);
        push(X2, Y2, Z2, 3'h7);
        rdchk(8'h00, 8'hFF);
        rdchk(8'h01, hi(X2));
        rdchk(8'h00, 8'hEE);
        rdchk(8'h03, hi(Y2));
        rdchk(8'h05, hi(Z2));
        rdchk(8'h00, 8'h00);
        push(X3, Y2, Z2, 3'h1);
        rdchk(8'h00, 8'h09);
        rdchk(8'h01, hi(X3));
        rdchk(8'h00, 8'h00);
    endtask

    // Standby keeps samples; reactivation clears them; fast read skips lows
    task automatic s_modes;
        logic [7:0] e [0:4];
        host.wr(8'h2A, 8'h00);
        rdchk(8'h01, hi(X3));
        host.wr(8'h2A, 8'h03);
        rdchk(8'h2A, 8'h03);
        rdchk(8'h01, 8'h00);
        push(X1, Y1, Z1, 3'h7);
        e = '{8'h0F, hi(X1), hi(Y1), hi(Z1), 8'h00};
        host.rd(8'h00, 5);
        for (int i = 0; i < 5; i++) begin
            chk(host.rx[i], e[i]);
        end
    endtask

    // Offset range jumps to the identity byte; stop forgets the pointer
    task automatic s_incr;
        host.wr(8'h2A, 8'h00);
        host.rd(8'h2F, 4);
        chk(host.rx[0], 8'h5A);
        chk(host.rx[1], 8'h00);
        chk(host.rx[2], 8'h00);
        chk(host.rx[3], 8'h6C);
        // Leave the pointer on a non-zero byte so a surviving pointer shows
        rdchk(8'h2E, 8'h00);
        host.rd_cur(1);
        chk(host.rx[0], 8'h00);
        // Soft reset self-clears and restores control and offsets
        host.wr(8'h2B, 8'h40);
        rdchk(8'h2B, 8'h00);
        rdchk(8'h2A, 8'h00);
        rdchk(8'h2F, 8'h00);
        chk(host.nacks[7:0], 8'h00);
    endtask

    task automatic end_of_test;
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        err_total = 0;
        num_checks = 0;
        reset_n = 1'b0;
        smp_valid = 1'b0;
        axis_en = 3'h0;
        {sx, sy, sz} = 30'h0;
        repeat (10) @(posedge sys_clk);
        #2 reset_n = 1'b1;
        repeat (5) @(posedge sys_clk);
        s_reset;
        s_config;
        s_burst;
        s_overwrite;
        s_modes;
        s_incr;
        end_of_test;
    end

    // A hung bus would otherwise stall forever; normal run is well under 1 ms
    initial begin
        #2000000;
        err_total++;
        end_of_test;
    end
endmodule
